// *** src/radio_packet_fifo_sync_detect.v ***
// Packet data path: store, shift register, framer, pattern detection
`timescale 1ns/10ps
`include "radio_fifo_defines.vh"

module radio_packet_fifo_sync_detect (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [2:0]  mode,
  input  wire        packet_mode,
  input  wire        bit_sync_enable,
  input  wire        host_cs_n,
  input  wire        host_wr_stb,
  input  wire [7:0]  host_wr_data,
  input  wire        host_rd_stb,
  output wire [7:0]  host_rd_data,
  input  wire        spill_clear_stb,
  input  wire [5:0]  fill_watermark_value,
  input  wire        pattern_detect_enable,
  input  wire [2:0]  pattern_length_field,
  input  wire [63:0] pattern_value_field,
  input  wire        bit_clk,
  input  wire        rx_bit,
  output wire        tx_bit,
  input  wire        general_io_two_in,
  output wire        general_io_two_out,
  output wire        general_io_two_oe,
  output wire        store_drained_flag,
  output wire        store_brimming_flag,
  output wire        store_spill_flag,
  output wire        fill_watermark_flag,
  output wire        frame_tx_done_flag,
  output wire        pattern_match_flag,
  output wire        mode_settled_flag
);

  localparam [4:0] TX_IDLE = 5'h01;
  localparam [4:0] TX_PRE  = 5'h02;
  localparam [4:0] TX_SYNC = 5'h04;
  localparam [4:0] TX_DATA = 5'h08;
  localparam [4:0] TX_DONE = 5'h10;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  reg [1:0] bclk_s_q;
  reg [1:0] rxb_s_q;
  reg [1:0] cs_s_q;
  reg [1:0] gio_s_q;
  reg       bclk_prev_q;
  reg       cs_prev_q;
  wire      bit_edge;
  wire      cs_fall;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bclk_s_q    <= 2'h0;
      rxb_s_q     <= 2'h0;
      cs_s_q      <= 2'h3;
      gio_s_q     <= 2'h0;
      bclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
    end else begin
      bclk_s_q    <= {bclk_s_q[0], bit_clk};
      rxb_s_q     <= {rxb_s_q[0], rx_bit};
      cs_s_q      <= {cs_s_q[0], host_cs_n};
      gio_s_q     <= {gio_s_q[0], general_io_two_in};
      bclk_prev_q <= bclk_s_q[1];
      cs_prev_q   <= cs_s_q[1];
    end
  end

  assign bit_edge = bclk_s_q[1] & ~bclk_prev_q;
  assign cs_fall  = ~cs_s_q[1] & cs_prev_q;

  // ---------------------------------------------------------------
  // Mode tracking, store clearing and settle timing
  // ---------------------------------------------------------------
  reg  [2:0] mode_prev_q;
  reg  [7:0] settle_cnt_q;
  wire       in_tx;
  wire       in_rx;
  wire       mode_chg;
  wire       mode_clear;
  wire       store_clear;
  wire [31:0] settle_cycles;
  wire [31:0] tx_exit_cycles;

  assign settle_cycles  = `SETTLE_CYC;
  assign tx_exit_cycles = `TX_EXIT_CYC;
  assign in_tx    = (mode == `MODE_TX);
  assign in_rx    = (mode == `MODE_RX);
  assign mode_chg = (mode != mode_prev_q);
  assign mode_clear = mode_chg & ((mode_prev_q == `MODE_TX) | in_rx |
                      ((mode_prev_q == `MODE_RX) & in_tx));
  assign store_clear = mode_clear | spill_clear_stb;

  // Leaving transmit lets the last bits drain, so it settles slower
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_prev_q  <= `MODE_SLEEP;
      settle_cnt_q <= 8'h00;
    end else begin
      mode_prev_q <= mode;
      if (mode_chg) begin
        settle_cnt_q <= (mode_prev_q == `MODE_TX) ?
                        tx_exit_cycles[7:0] : settle_cycles[7:0];
      end else if (settle_cnt_q != 8'h00) begin
        settle_cnt_q <= settle_cnt_q - 8'h01;
      end
    end
  end

  assign mode_settled_flag = (settle_cnt_q == 8'h00) & ~mode_chg;

  // ---------------------------------------------------------------
  // Store and its access paths
  // ---------------------------------------------------------------
  wire [7:0] head_data;
  wire [6:0] level;
  wire       empty;
  wire       full;
  wire       overflow;
  wire       push;
  wire       pop;
  wire [7:0] push_data;
  wire       host_pop;
  reg        rx_push;
  reg  [7:0] rx_byte;
  reg        pop_tx;

  // Store is idle in continuous operation
  assign host_pop  = packet_mode & host_rd_stb & ~in_tx;
  assign push      = packet_mode &
                     (in_rx ? rx_push : host_wr_stb);
  assign push_data = in_rx ? rx_byte : host_wr_data;
  assign pop       = host_pop | (packet_mode & pop_tx);

  byte_store u_store (
    .clk       (clk),
    .reset_n   (reset_n),
    .push      (push),
    .push_data (push_data),
    .pop       (pop),
    .clear     (store_clear),
    .head_data (head_data),
    .level     (level),
    .empty     (empty),
    .full      (full),
    .overflow  (overflow)
  );

  assign store_brimming_flag = full;

  // ---------------------------------------------------------------
  // Host read data, drained, spill and watermark flags
  // ---------------------------------------------------------------
  reg [7:0] rd_data_q;
  reg       drained_q;
  reg       spill_q;
  reg       wm_q;
  reg       wm_ev_q;
  reg       wm_frozen_q;
  reg       empty_prev_q;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q    <= 8'h00;
      drained_q    <= 1'b1;
      spill_q      <= 1'b0;
      wm_q         <= 1'b0;
      wm_ev_q      <= 1'b0;
      wm_frozen_q  <= 1'b0;
      empty_prev_q <= 1'b1;
    end else begin
      empty_prev_q <= empty;
      if (host_pop & ~empty) begin
        rd_data_q <= head_data;
      end
      // Held while a read is under way so the host sees a stable value
      if (cs_s_q[1] | cs_fall) begin
        drained_q <= empty;
      end
      if (overflow) begin
        spill_q <= 1'b1;
      end else if (spill_clear_stb) begin
        spill_q <= 1'b0;
      end
      wm_ev_q <= push | pop;
      if (full) begin
        wm_frozen_q <= 1'b1;
      end else if (empty) begin
        wm_frozen_q <= 1'b0;
      end
      if (wm_ev_q & ~wm_frozen_q & ~full) begin
        wm_q <= (level > {1'b0, fill_watermark_value});
      end
    end
  end

  assign host_rd_data        = rd_data_q;
  assign store_drained_flag  = drained_q;
  assign store_spill_flag    = spill_q;
  assign fill_watermark_flag = wm_q;

  // ---------------------------------------------------------------
  // Transmit framer and shift register
  // ---------------------------------------------------------------
  reg  [4:0]  tx_state_q;
  reg  [4:0]  tx_state_d;
  reg  [2:0]  idx_q;
  reg  [2:0]  idx_d;
  reg  [7:0]  tx_sh_q;
  reg  [2:0]  bits_left_q;
  reg         tx_bit_q;
  reg         done_q;
  reg         fetch_ok;
  reg  [7:0]  fetch_byte;
  reg         done_set;
  wire        tx_run;
  wire        need;
  wire [63:0] sync_al;

  assign tx_run  = in_tx & packet_mode;
  assign need    = tx_run & bit_edge & (bits_left_q == 3'h0);
  assign sync_al = pattern_value_field << {idx_q, 3'h0};

  always @* begin
    tx_state_d = tx_state_q;
    idx_d      = idx_q;
    fetch_ok   = 1'b0;
    fetch_byte = 8'h00;
    pop_tx     = 1'b0;
    done_set   = 1'b0;
    case (tx_state_q)
      TX_IDLE: begin
        idx_d = 3'h0;
        if (tx_run) begin
          tx_state_d = TX_PRE;
        end
      end
      TX_PRE: begin
        fetch_ok   = 1'b1;
        fetch_byte = `PREAMBLE_BYTE;
        if (need) begin
          idx_d = idx_q + 3'h1;
          if (idx_q == `PREAMBLE_LAST) begin
            idx_d      = 3'h0;
            tx_state_d = TX_SYNC;
          end
        end
      end
      TX_SYNC: begin
        fetch_ok   = 1'b1;
        fetch_byte = sync_al[63:56];
        if (need) begin
          idx_d = idx_q + 3'h1;
          if (idx_q == pattern_length_field) begin
            tx_state_d = TX_DATA;
          end
        end
      end
      TX_DATA: begin
        fetch_ok   = ~empty;
        fetch_byte = head_data;
        if (need) begin
          if (empty) begin
            tx_state_d = TX_DONE;
            done_set   = 1'b1;
          end else begin
            pop_tx = 1'b1;
          end
        end
      end
      TX_DONE: begin
        tx_state_d = TX_DONE;
      end
      default: begin
        tx_state_d = TX_IDLE;
      end
    endcase
    if (!tx_run) begin
      tx_state_d = TX_IDLE;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_q  <= TX_IDLE;
      idx_q       <= 3'h0;
      tx_sh_q     <= 8'h00;
      bits_left_q <= 3'h0;
      tx_bit_q    <= 1'b0;
      done_q      <= 1'b0;
    end else begin
      tx_state_q <= tx_state_d;
      idx_q      <= idx_d;
      if (done_set) begin
        done_q <= 1'b1;
      end else if (!in_tx) begin
        done_q <= 1'b0;
      end
      if (in_tx & ~packet_mode & bit_edge) begin
        tx_bit_q <= gio_s_q[1];
      end else if (tx_run & bit_edge) begin
        if (bits_left_q != 3'h0) begin
          tx_bit_q    <= tx_sh_q[7];
          tx_sh_q     <= {tx_sh_q[6:0], 1'b0};
          bits_left_q <= bits_left_q - 3'h1;
        end else if (fetch_ok) begin
          tx_bit_q    <= fetch_byte[7];
          tx_sh_q     <= {fetch_byte[6:0], 1'b0};
          bits_left_q <= 3'h7;
        end
      end
      if (!tx_run) begin
        bits_left_q <= 3'h0;
      end
    end
  end

  assign tx_bit             = tx_bit_q;
  assign frame_tx_done_flag = done_q;

  // ---------------------------------------------------------------
  // Receive: pattern detection and byte assembly
  // ---------------------------------------------------------------
  reg  [2:0] rx_cnt_q;
  reg  [6:0] rx_sh_q;
  reg        match_q;
  reg        gio_out_q;
  wire       det_en;
  wire       rx_shift;
  wire       hit;

  // Packet operation runs the bit synchroniser by itself
  assign det_en   = in_rx & pattern_detect_enable &
                    (packet_mode | bit_sync_enable);
  assign rx_shift = bit_edge & in_rx & packet_mode & match_q;

  pattern_detector u_detect (
    .clk      (clk),
    .reset_n  (reset_n),
    .enable   (det_en),
    .shift_en (bit_edge),
    .bit_in   (rxb_s_q[1]),
    .length   (pattern_length_field),
    .pattern  (pattern_value_field),
    .hit      (hit)
  );

  always @* begin
    rx_push = rx_shift & (rx_cnt_q == 3'h7);
    rx_byte = {rx_sh_q, rxb_s_q[1]};
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_cnt_q  <= 3'h0;
      rx_sh_q   <= 7'h00;
      match_q   <= 1'b0;
      gio_out_q <= 1'b0;
    end else begin
      gio_out_q <= rxb_s_q[1];
      if (hit & ~match_q) begin
        match_q <= 1'b1;
      end else if (!in_rx | (empty & ~empty_prev_q) | store_clear) begin
        match_q <= 1'b0;
      end
      if (!match_q) begin
        rx_cnt_q <= 3'h0;
      end else if (rx_shift) begin
        rx_sh_q  <= {rx_sh_q[5:0], rxb_s_q[1]};
        rx_cnt_q <= rx_cnt_q + 3'h1;
      end
    end
  end

  assign pattern_match_flag = match_q;
  assign general_io_two_out = gio_out_q;
  assign general_io_two_oe  = in_rx & ~packet_mode;

endmodule // radio_packet_fifo_sync_detect

// *** pkg/radio_fifo_defines.vh ***
// Constants for the radio packet store, framer and pattern detector
// Function
// - One-byte-wide store, sixty-four entries deep
// - Transmit pops bytes, shifts out MSB first
// - Receive gathers bits, pushes each full byte
// - Drained flag high when empty, updates at select fall
// - Brimming flag high exactly when store full
// - Write into full store sets spill, drops byte
// - Writing one clears spill and empties store
// - Frame-done flag rises after final bit sent
// - Watermark compared only on store read or write
// - Watermark flag frozen from full until empty
// - Mode changes keep or empty store per table
// - Detection needs enable; synchronizer per operation mode
// - Detector shifts bits, compares, flags a match
// - First bit meets bit 7, last bit 0
// - Match flag clears leaving receive or on emptying
// - Pattern length one to eight bytes, also transmit
// - Packet operation frames and strips preamble and pattern
// - Continuous operation passes bits on data pin
// - Continuous operation leaves store and framer idle
`ifndef RADIO_FIFO_DEFINES_VH
`define RADIO_FIFO_DEFINES_VH

`define STORE_DEPTH      64
`define STORE_AW         6
`define STORE_CW         7

`define MODE_SLEEP       3'h0
`define MODE_STDBY       3'h1
`define MODE_TX          3'h3
`define MODE_RX          3'h5

`define PREAMBLE_BYTE    8'hAA
`define PREAMBLE_LAST    3'h2

`define CLK_PERIOD_NS    40
`define MODE_SETTLE_NS   200
`define TX_EXIT_NS       2000
`define SETTLE_CYC  ((`MODE_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TX_EXIT_CYC ((`TX_EXIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** src/byte_store.v ***
// Sixty-four byte first-in first-out store with level and spill detect
`timescale 1ns/10ps
`include "radio_fifo_defines.vh"

module byte_store (
  input  wire                   clk,
  input  wire                   reset_n,
  input  wire                   push,
  input  wire [7:0]             push_data,
  input  wire                   pop,
  input  wire                   clear,
  output wire [7:0]             head_data,
  output wire [`STORE_CW-1:0]   level,
  output wire                   empty,
  output wire                   full,
  output wire                   overflow
);

  reg [7:0]           mem [0:`STORE_DEPTH-1];
  reg [`STORE_AW-1:0] wr_ptr_q;
  reg [`STORE_AW-1:0] rd_ptr_q;
  reg [`STORE_CW-1:0] count_q;
  wire                push_ok;
  wire                pop_ok;

  assign empty     = (count_q == 7'h00);
  assign full      = (count_q == 7'h40);
  assign overflow  = push & full;
  assign push_ok   = push & ~full;
  assign pop_ok    = pop & ~empty;
  assign head_data = mem[rd_ptr_q];
  assign level     = count_q;

  always @(posedge clk) begin
    if (push_ok & ~clear) begin
      mem[wr_ptr_q] <= push_data;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= 6'h00;
      rd_ptr_q <= 6'h00;
      count_q  <= 7'h00;
    end else if (clear) begin
      wr_ptr_q <= 6'h00;
      rd_ptr_q <= 6'h00;
      count_q  <= 7'h00;
    end else begin
      if (push_ok) begin
        wr_ptr_q <= wr_ptr_q + 6'h01;
      end
      if (pop_ok) begin
        rd_ptr_q <= rd_ptr_q + 6'h01;
      end
      count_q <= count_q + {6'h00, push_ok} - {6'h00, pop_ok};
    end
  end

endmodule // byte_store

// *** src/pattern_detector.v ***
// Serial pattern detector comparing the last received bits to a pattern
`timescale 1ns/10ps

module pattern_detector (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        enable,
  input  wire        shift_en,
  input  wire        bit_in,
  input  wire [2:0]  length,
  input  wire [63:0] pattern,
  output wire        hit
);

  reg  [63:0] win_q;
  wire [7:0]  byte_hit;

  // Window clears while disabled; zeros never match a legal pattern
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      win_q <= 64'h0000000000000000;
    end else if (!enable) begin
      win_q <= 64'h0000000000000000;
    end else if (shift_en) begin
      win_q <= {win_q[62:0], bit_in};
    end
  end

  // Window byte k (k=0 newest) meets pattern byte (length-k)
  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1) begin : g_cmp
      localparam [2:0] KK = k;
      wire [2:0]  idx = length - KK;
      wire [63:0] al  = pattern << {idx, 3'h0};
      assign byte_hit[k] = (KK > length) |
                           (win_q[8*k+7:8*k] == al[63:56]);
    end
  endgenerate

  assign hit = enable & (&byte_hit);

endmodule // pattern_detector

// *** verification/radio_fifo_props.sv ***
// Concurrent checks on the store, spill, settle and match ports
`timescale 1ns/10ps
`include "radio_fifo_defines.vh"
module radio_fifo_props (
  input logic       clk,
  input logic       reset_n,
  input logic [2:0] mode,
  input logic       packet_mode,
  input logic       host_cs_n,
  input logic       host_wr_stb,
  input logic       host_rd_stb,
  input logic [7:0] host_rd_data,
  input logic       spill_clear_stb,
  input logic       store_drained_flag,
  input logic       store_brimming_flag,
  input logic       store_spill_flag,
  input logic       fill_watermark_flag,
  input logic       frame_tx_done_flag,
  input logic       pattern_match_flag,
  input logic       mode_settled_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Level flag lags an access by two cycles, so wait three before judging
  logic [1:0] quiet_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) quiet_q <= 2'h0;
    else if (host_wr_stb || host_rd_stb || spill_clear_stb || $changed(mode))
      quiet_q <= 2'h0;
    else if (quiet_q != 2'h3) quiet_q <= quiet_q + 2'h1;
  end
  chk_spill_on_full: assert property (
    store_brimming_flag && host_wr_stb && packet_mode && mode != `MODE_RX
    |=> store_spill_flag) else $error("spill not set on full write");
  chk_spill_holds: assert property (
    store_spill_flag && !spill_clear_stb && $stable(mode)
    |=> store_spill_flag) else $error("spill dropped by itself");
  chk_clear_spill: assert property (
    spill_clear_stb && !(store_brimming_flag && host_wr_stb)
    |=> !store_spill_flag && !store_brimming_flag)
    else $error("spill clear left flag or full store");
  chk_drain_clear: assert property (
    (spill_clear_stb && host_cs_n && !host_wr_stb && mode != `MODE_RX
    ##1 (host_cs_n && !host_wr_stb) [*5]) |-> store_drained_flag)
    else $error("store not drained after clear");
  chk_brim_cause: assert property (
    $rose(store_brimming_flag) && mode != `MODE_RX |-> $past(host_wr_stb))
    else $error("full without a write");
  chk_settle_gap: assert property (
    $changed(mode) |=> !mode_settled_flag [*3] ##[1:60] mode_settled_flag)
    else $error("mode settle timing wrong");
  chk_level_still: assert property (
    quiet_q == 2'h3 && (mode == `MODE_STDBY || mode == `MODE_SLEEP)
    |=> $stable(fill_watermark_flag)) else $error("level flag moved idle");
  chk_rd_hold: assert property (
    $changed(host_rd_data) |-> $past(host_rd_stb))
    else $error("read data changed without a pop");
  chk_match_exit: assert property (
    $past(mode) == `MODE_RX && mode != `MODE_RX
    |-> ##[0:2] !pattern_match_flag) else $error("match kept after rx");
  cov_spill: cover property (store_spill_flag);
  cov_match: cover property (pattern_match_flag);
  cov_sent: cover property (frame_tx_done_flag);
endmodule // radio_fifo_props
bind radio_packet_fifo_sync_detect radio_fifo_props chk (
  .clk, .reset_n, .mode, .packet_mode, .host_cs_n, .host_wr_stb,
  .host_rd_stb, .host_rd_data, .spill_clear_stb, .store_drained_flag,
  .store_brimming_flag, .store_spill_flag, .fill_watermark_flag,
  .frame_tx_done_flag, .pattern_match_flag, .mode_settled_flag
);

// *** verification/modem_model.sv ***
// Serial modem model: bit clock, demodulated bits, modulator capture
`timescale 1ns/10ps
module modem_model (
  output logic bit_clk,
  output logic rx_bit,
  input  logic tx_bit
);
  // Bit clock stands still between frames
  initial begin
    bit_clk = 1'b0;
    rx_bit  = 1'b0;
  end
  task automatic send_byte(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      rx_bit = d[i];
      #160 bit_clk = 1'b1;
      #160 bit_clk = 1'b0;
    end
    // Idle line shows the inverse so a stale bit is never mistaken;
    // it moves off the clock edges and never in a call's first step
    #10 rx_bit = ~d[0];
    #30;
  endtask
  task automatic recv_byte(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      bit_clk = 1'b1;
      #160 bit_clk = 1'b0;
      #150 d[i] = tx_bit;
      #10;
    end
  endtask
endmodule // modem_model

// *** verification/radio_packet_fifo_sync_detect_tb.sv ***
// Self-checking bench for the radio packet store and pattern detector
`timescale 1ns/10ps
`include "radio_fifo_defines.vh"
module radio_packet_fifo_sync_detect_tb;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [2:0]  mode = `MODE_STDBY;
  logic        packet_mode = 1'b1;
  logic        bit_sync_enable = 1'b0;
  logic        host_cs_n = 1'b1;
  logic        host_wr_stb = 1'b0;
  logic [7:0]  host_wr_data = 8'h00;
  logic        host_rd_stb = 1'b0;
  logic        spill_clear_stb = 1'b0;
  logic [5:0]  fill_watermark_value = 6'h02;
  logic        pattern_detect_enable = 1'b1;
  logic [2:0]  pattern_length_field = 3'h1;
  logic [63:0] pattern_value_field = 64'hD391_1122_3344_5566;
  logic        host_io = 1'b0;
  logic        bit_clk, rx_bit, tx_bit, gio_out, gio_oe;
  logic [7:0]  host_rd_data, b;
  logic        drained, brim, spill, wm, sent, match, settled;
  int          errors = 0;
  int          cmp_count = 0;
  logic [5:0]  tbl [5] = '{{`MODE_STDBY, `MODE_SLEEP},
    {`MODE_SLEEP, `MODE_STDBY}, {`MODE_SLEEP, `MODE_TX},
    {`MODE_TX, `MODE_STDBY}, {`MODE_STDBY, `MODE_RX}};
  logic [4:0]  clr_exp = 5'b11000;
  logic [7:0]  txf [7] = '{8'hAA, 8'hAA, 8'hAA, 8'hD3, 8'h91, 8'hC6, 8'h1B};
  wire         general_io_two_in = gio_oe ? gio_out : host_io;
  always #20 clk = ~clk;
  radio_packet_fifo_sync_detect dut (
    .clk, .reset_n, .mode, .packet_mode, .bit_sync_enable, .host_cs_n,
    .host_wr_stb, .host_wr_data, .host_rd_stb, .host_rd_data,
    .spill_clear_stb, .fill_watermark_value, .pattern_detect_enable,
    .pattern_length_field, .pattern_value_field, .bit_clk, .rx_bit, .tx_bit,
    .general_io_two_in, .general_io_two_out(gio_out),
    .general_io_two_oe(gio_oe), .store_drained_flag(drained),
    .store_brimming_flag(brim), .store_spill_flag(spill),
    .fill_watermark_flag(wm), .frame_tx_done_flag(sent),
    .pattern_match_flag(match), .mode_settled_flag(settled)
  );
  modem_model modem (.bit_clk, .rx_bit, .tx_bit);
  // ------------------------------------------------------------
  // Host access tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Strobes are spaced two cycles so no signal is set twice in a step
  task automatic push(input logic [7:0] d);
    host_wr_data = d;
    host_wr_stb = 1'b1;
    tick(1);
    host_wr_stb = 1'b0;
    tick(1);
  endtask
  task automatic pop(input logic [7:0] exp);
    host_rd_stb = 1'b1;
    tick(1);
    host_rd_stb = 1'b0;
    tick(1);
    chk(host_rd_data, exp);
  endtask
  task automatic clr;
    spill_clear_stb = 1'b1;
    tick(1);
    spill_clear_stb = 1'b0;
    tick(5);
  endtask
  task automatic mode_to(input logic [2:0] m);
    mode = m;
    tick(2);
    for (int i = 0; i < 80 && settled !== 1'b1; i++) tick(1);
    chk(settled, 1'b1);
  endtask
  task automatic print_verdict;
    $display("comparisons=%0d mismatches=%0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  // A full run needs about 80 us; the limit leaves wide margin
  initial begin
    #3000000;
    errors++;
    print_verdict;
  end
  initial begin
    tick(4);
    reset_n = 1'b1;
    tick(1);
    // Reset leaves the tracker in sleep, so standby counts as a change
    chk({drained, brim, spill, settled, wm, sent, match}, 8'h40);
    chk(host_rd_data, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 3; i++) push(8'h10 + 8'(i));
    tick(3);
    chk(wm, 1'b1);
    fill_watermark_value = 6'h0A;
    tick(4);
    chk(wm, 1'b1);
    push(8'h13);
    tick(3);
    chk(wm, 1'b0);
    for (int i = 4; i < 63; i++) push(8'h10 + 8'(i));
    chk(brim, 1'b0);
    push(8'h4F);
    chk(brim, 1'b1);
    push(8'hEE);
    chk(spill, 1'b1);
    for (int i = 0; i < 59; i++) pop(8'h10 + 8'(i));
    chk(wm, 1'b1);
    for (int i = 59; i < 63; i++) pop(8'h10 + 8'(i));
    pop(8'h4F);
    tick(4);
    chk(drained, 1'b1);
    pop(8'h4F);
    push(8'h01);
    tick(3);
    chk(wm, 1'b0);
    clr;
    chk({spill, drained}, 8'h01);
    $display("test store done");
    push(8'h77);
    host_cs_n = 1'b0;
    tick(5);
    pop(8'h77);
    tick(4);
    chk(drained, 1'b0);
    host_cs_n = 1'b1;
    tick(5);
    chk(drained, 1'b1);
    $display("test select done");
    foreach (tbl[k]) begin
      clr;
      push(8'h3C);
      mode_to(tbl[k][5:3]);
      mode_to(tbl[k][2:0]);
      tick(5);
      chk(drained, clr_exp[k]);
      mode_to(`MODE_STDBY);
    end
    $display("test modes done");
    mode_to(`MODE_RX);
    modem.send_byte(8'h5B);
    modem.send_byte(8'hD3);
    tick(4);
    chk(match, 1'b0);
    modem.send_byte(8'h91);
    tick(4);
    chk(match, 1'b1);
    modem.send_byte(8'hA5);
    modem.send_byte(8'h3C);
    tick(4);
    pop(8'hA5);
    mode_to(`MODE_STDBY);
    chk(match, 1'b0);
    pop(8'h3C);
    $display("test receive done");
    push(8'hC6);
    push(8'h1B);
    mode_to(`MODE_TX);
    foreach (txf[k]) begin
      modem.recv_byte(b);
      chk(b, txf[k]);
    end
    chk(sent, 1'b0);
    modem.recv_byte(b);
    tick(4);
    chk(sent, 1'b1);
    mode_to(`MODE_STDBY);
    $display("test transmit done");
    pattern_detect_enable = 1'b0;
    mode_to(`MODE_RX);
    modem.send_byte(8'hD3);
    modem.send_byte(8'h91);
    tick(4);
    chk(match, 1'b0);
    pattern_detect_enable = 1'b1;
    pattern_length_field = 3'h0;
    pattern_value_field = 64'h5A6B_7C8D_9EAF_B1C2;
    tick(2);
    modem.send_byte(8'h5A);
    tick(4);
    chk(match, 1'b1);
    mode_to(`MODE_STDBY);
    chk(match, 1'b0);
    $display("test pattern done");
    packet_mode = 1'b0;
    bit_sync_enable = 1'b1;
    push(8'h99);
    tick(4);
    chk(drained, 1'b1);
    mode_to(`MODE_RX);
    modem.send_byte(8'h01);
    tick(4);
    // Pin follows the line, which idles at the last bit inverted
    chk({gio_oe, gio_out}, 8'h02);
    modem.send_byte(8'hFE);
    tick(4);
    chk({gio_oe, gio_out}, 8'h03);
    mode_to(`MODE_TX);
    modem.recv_byte(b);
    chk(b, 8'h00);
    host_io = 1'b1;
    modem.recv_byte(b);
    chk(b, 8'hFF);
    $display("test continuous done");
    print_verdict;
  end
endmodule // radio_packet_fifo_sync_detect_tb
